// ### hw/sp_regs.svh
// register offsets, bit positions, reset values and timing counts of the self-programming block
// Operation
// - sig read armed plus quick load returns byte
// - arming bits self-clear after read or timeout
// - unarmed load reads normal program flash
// - id bytes 0,2,4; calibration at 1
// - serial bytes at 0x0E-0x17, 0x14 unused
// - system reset never aborts running flash write; power-on reset does
// - write duration timed by rc oscillator
// - each flash write takes 3.2-3.4ms
// - blocked section unreadable during erase/write
// - store accepted only within four cycles
// - busy flag held until re-enable written
`ifndef SP_REGS_SVH
`define SP_REGS_SVH
`define SP_CTRL_ADDR 6'h00
`define SP_CTRL_RST 8'h00
`define SP_EN_POS 0
`define SP_ERASE_POS 1
`define SP_WRITE_POS 2
`define SP_LOCK_POS 3
`define SP_REEN_POS 4
`define SP_SIG_POS 5
`define SP_RWWB_POS 6
`define SP_LPM_WIN 3
`define SP_SPM_WIN 4
`define SP_WIN_RST 3'h0
`define SP_PROG_MIN_US 3200
`define SP_PROG_MAX_US 3400
`define SP_UNASSIGNED_BYTE 8'hFF
`define SP_ROW_BYTES 24
`endif

// ### hw/sp_pkg.sv
// types shared by the self-programming block
package sp_pkg;
  // core request: load / store strobes with the z pointer
  typedef struct packed {
    logic lpm;
    logic spm;
    logic [15:0] z;
  } sp_cpu_req_t;
  // running flash operation towards the array
  typedef struct packed {
    logic erase;
    logic write;
    logic lock;
    logic halt;
    logic [14:0] word;
  } sp_flash_op_t;
endpackage : sp_pkg

// ### hw/sp_selfprog.sv
// self-programming control: signature row read, store window, rc-timed flash writes
`timescale 1ns/1ps
`include "sp_regs.svh"
module sp_selfprog #(
  parameter int RC_KHZ = 8000,
  parameter int PROG_TICKS = (`SP_PROG_MIN_US + `SP_PROG_MAX_US) / 2 * RC_KHZ / 1000,
  parameter logic [14:0] BLOCKED_DURING_WRITE_SECTION_START = 15'h0C00,
  parameter logic [8*`SP_ROW_BYTES-1:0] SIG_ROW = {8*`SP_ROW_BYTES{1'b0}} // arbitrary row content
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic por_b,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire sp_pkg::sp_cpu_req_t cpu_req,
  input wire logic [15:0] flash_rdata,
  input wire logic eeprom_busy,
  input wire logic rc_osc,
  output logic [7:0] lpm_data,
  output logic lpm_valid,
  output sp_pkg::sp_flash_op_t flash_op,
  output logic rww_busy
);
  import sp_pkg::*;

  localparam int MIN_TICKS = (`SP_PROG_MIN_US * RC_KHZ + 999) / 1000;
  localparam int MAX_TICKS = `SP_PROG_MAX_US * RC_KHZ / 1000;

  // refuse settings the counters or the sampler cannot serve
  if (PROG_TICKS < 1 || PROG_TICKS > 65535 || RC_KHZ * 2 >= 250000) begin : g_bad_param
    $error("sp_selfprog: bad timing parameters");
  end

  // signature byte at a row address; unassigned slots read as a fixed value
  function automatic logic [7:0] sp_sig_byte(input logic [15:0] a);
    logic ok;
    ok = (a == 16'h0000) || (a == 16'h0001) || (a == 16'h0002) || (a == 16'h0004);
    ok = ok || ((a >= 16'h000E) && (a <= 16'h0017) && (a != 16'h0014));
    if (ok) begin
      return SIG_ROW[8*a[4:0] +: 8];
    end
    return `SP_UNASSIGNED_BYTE;
  endfunction : sp_sig_byte

  // word address lies in the section that is blocked while writing
  function automatic logic sp_in_rww(input logic [14:0] w);
    return w < BLOCKED_DURING_WRITE_SECTION_START;
  endfunction : sp_in_rww

  logic [5:0] cmd_ff;
  logic [2:0] win_ff;
  logic rc_s1_ff, rc_s2_ff, rc_s3_ff;
  logic busy_ff;
  logic [15:0] prog_cnt_ff;
  logic rww_busy_ff;
  logic [7:0] reg_rdata_ff, lpm_data_ff;
  logic lpm_valid_ff;
  sp_flash_op_t flash_op_ff;

  logic ctrl_wr, armed, sig_mode, lpm_sig, spm_take, prog_start, reen_take, rc_tick, prog_done, rww_hit;
  logic [7:0] sig_pick, flash_byte;

  // command decode from the armed bits and the open window
  assign ctrl_wr = reg_wr && (reg_addr == `SP_CTRL_ADDR) && !eeprom_busy && !busy_ff;
  assign armed = cmd_ff[`SP_EN_POS];
  assign sig_mode = armed && cmd_ff[`SP_SIG_POS];
  assign lpm_sig = cpu_req.lpm && sig_mode && (win_ff >= 3'(`SP_SPM_WIN - `SP_LPM_WIN + 1));
  assign spm_take = cpu_req.spm && armed && !sig_mode && (win_ff != 3'h0) && !busy_ff;
  assign prog_start = spm_take && (cmd_ff[`SP_ERASE_POS] || cmd_ff[`SP_WRITE_POS] || cmd_ff[`SP_LOCK_POS]);
  assign reen_take = spm_take && cmd_ff[`SP_REEN_POS];
  assign rc_tick = rc_s2_ff && !rc_s3_ff;
  assign prog_done = busy_ff && rc_tick && (prog_cnt_ff == 16'h0000);
  assign rww_hit = rww_busy_ff && sp_in_rww(cpu_req.z[15:1]);
  assign sig_pick = sp_sig_byte(cpu_req.z);
  assign flash_byte = cpu_req.z[0] ? flash_rdata[15:8] : flash_rdata[7:0];

  // control bits: armed by a write, cleared on use, on timeout or at the end of a write
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_ff <= 6'(`SP_CTRL_RST);
    end else if (ctrl_wr) begin
      cmd_ff <= reg_wdata[5:0];
    end else if (lpm_sig) begin
      cmd_ff <= 6'h00;
    end else if (spm_take && !prog_start) begin
      cmd_ff <= 6'h00;
    end else if (prog_done) begin
      cmd_ff <= 6'h00;
    end else if (sig_mode && win_ff == 3'(`SP_SPM_WIN - `SP_LPM_WIN + 1) && !cpu_req.lpm) begin
      cmd_ff <= 6'h00;
    end else if (win_ff == 3'h1 && !spm_take && !busy_ff) begin
      cmd_ff <= 6'h00;
    end
  end

  // cycles left in which a load or store may follow the arming write
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      win_ff <= `SP_WIN_RST;
    end else if (ctrl_wr) begin
      win_ff <= reg_wdata[`SP_EN_POS] ? 3'(`SP_SPM_WIN) : 3'h0;
    end else if (lpm_sig || spm_take) begin
      win_ff <= 3'h0;
    end else if (win_ff != 3'h0) begin
      win_ff <= win_ff - 3'h1;
    end
  end

  // rc oscillator brought into the clock domain; s3 only serves the edge detect
  always_ff @(posedge ref_clk or negedge por_b) begin
    if (!por_b) begin
      rc_s1_ff <= 1'b0;
      rc_s2_ff <= 1'b0;
      rc_s3_ff <= 1'b0;
    end else begin
      rc_s1_ff <= rc_osc;
      rc_s2_ff <= rc_s1_ff;
      rc_s3_ff <= rc_s2_ff;
    end
  end

  // flash write timer on power-on reset only, so a system reset lets it finish
  always_ff @(posedge ref_clk or negedge por_b) begin
    if (!por_b) begin
      busy_ff <= 1'b0;
      prog_cnt_ff <= 16'h0000;
    end else if (prog_start) begin
      busy_ff <= 1'b1;
      prog_cnt_ff <= 16'(PROG_TICKS - 1);
    end else if (busy_ff && rc_tick) begin
      if (prog_cnt_ff == 16'h0000) begin
        busy_ff <= 1'b0;
      end else begin
        prog_cnt_ff <= prog_cnt_ff - 16'h0001;
      end
    end
  end

  // operation handed to the array, core halted for writes into its own section
  always_ff @(posedge ref_clk or negedge por_b) begin
    if (!por_b) begin
      flash_op_ff <= '0;
    end else if (prog_start) begin
      flash_op_ff.erase <= cmd_ff[`SP_ERASE_POS];
      flash_op_ff.write <= cmd_ff[`SP_WRITE_POS];
      flash_op_ff.lock <= cmd_ff[`SP_LOCK_POS] && !cmd_ff[`SP_ERASE_POS] && !cmd_ff[`SP_WRITE_POS];
      flash_op_ff.halt <= (cmd_ff[`SP_ERASE_POS] || cmd_ff[`SP_WRITE_POS]) && !sp_in_rww(cpu_req.z[15:1]);
      flash_op_ff.word <= cpu_req.z[15:1];
    end else if (prog_done) begin
      flash_op_ff <= '0;
    end
  end

  // blocked-section flag: set by erase/write there, cleared only by re-enable
  always_ff @(posedge ref_clk or negedge por_b) begin
    if (!por_b) begin
      rww_busy_ff <= 1'b0;
    end else if (prog_start && (cmd_ff[`SP_ERASE_POS] || cmd_ff[`SP_WRITE_POS]) && sp_in_rww(cpu_req.z[15:1])) begin
      rww_busy_ff <= 1'b1;
    end else if (reen_take) begin
      rww_busy_ff <= 1'b0;
    end
  end

  // load results: signature byte, normal flash byte, or blank for the blocked section
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      lpm_valid_ff <= 1'b0;
      lpm_data_ff <= 8'h00;
    end else begin
      lpm_valid_ff <= cpu_req.lpm;
      if (lpm_sig) begin
        lpm_data_ff <= sig_pick;
      end else if (rww_hit) begin
        lpm_data_ff <= `SP_UNASSIGNED_BYTE;
      end else begin
        lpm_data_ff <= flash_byte;
      end
    end
  end

  // register read port, enable bit reads set while a write runs
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_ff <= 8'h00;
    end else if (reg_rd && reg_addr == `SP_CTRL_ADDR) begin
      reg_rdata_ff <= {1'b0, rww_busy_ff, cmd_ff[5:1], cmd_ff[0] || busy_ff};
    end else begin
      reg_rdata_ff <= 8'h00;
    end
  end

  assign reg_rdata = reg_rdata_ff;
  assign lpm_data = lpm_data_ff;
  assign lpm_valid = lpm_valid_ff;
  assign flash_op = flash_op_ff;
  assign rww_busy = rww_busy_ff;

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  localparam int TICKS_M1 = PROG_TICKS - 1;

  AST_SIG_LOAD: assert property (lpm_sig |=> lpm_valid_ff && lpm_data_ff == $past(sig_pick))
    else $error("signature byte not returned");
  AST_SIG_CLEAR: assert property (lpm_sig |=> !cmd_ff[`SP_SIG_POS] && !cmd_ff[`SP_EN_POS])
    else $error("arming bits kept after signature read");
  AST_SIG_TIMEOUT: assert property ((ctrl_wr && reg_wdata[`SP_SIG_POS] && reg_wdata[`SP_EN_POS])
    ##1 !cpu_req.lpm [*3] |=> cmd_ff == 6'h00)
    else $error("arming bits kept after load window");
  AST_NORMAL_READ: assert property ((cpu_req.lpm && !sig_mode && !rww_hit) |=> lpm_data_ff == $past(flash_byte))
    else $error("unarmed load did not read flash");
  AST_GAP_BYTE: assert property ((lpm_sig && cpu_req.z == 16'h0014) |=> lpm_data_ff == `SP_UNASSIGNED_BYTE)
    else $error("unassigned address not blank");
  AST_RESET_KEEPS: assert property (@(posedge ref_clk) disable iff (!por_b)
    (busy_ff && !rst_b && !prog_done) |=> busy_ff)
    else $error("system reset aborted flash write");
  AST_RC_TIMED: assert property (@(posedge ref_clk) disable iff (!por_b)
    (busy_ff && !rc_tick) |=> prog_cnt_ff == $past(prog_cnt_ff))
    else $error("write timer moved without rc edge");
  AST_DURATION: assert property (@(posedge ref_clk) disable iff (!por_b)
    prog_start |=> busy_ff && prog_cnt_ff == 16'(TICKS_M1) && MIN_TICKS <= PROG_TICKS && PROG_TICKS <= MAX_TICKS)
    else $error("write duration out of range");
  AST_BLOCKED: assert property ((cpu_req.lpm && rww_hit && !lpm_sig) |=> lpm_data_ff == `SP_UNASSIGNED_BYTE)
    else $error("blocked section was readable");
  AST_SPM_WINDOW: assert property ((cpu_req.spm && win_ff == 3'h0) |=> !$rose(busy_ff))
    else $error("store accepted outside window");
  AST_RWW_HOLD: assert property (@(posedge ref_clk) disable iff (!por_b)
    (rww_busy_ff && !reen_take) |=> rww_busy_ff)
    else $error("busy flag dropped without re-enable");

  COV_SIG_READ: cover property (lpm_sig);
  COV_WRITE_DONE: cover property (prog_done);
  COV_REENABLE: cover property (rww_busy_ff ##1 reen_take);
endmodule : sp_selfprog

// ### bench/sp_core_model.sv
// partner model: flash array read port and free-running rc oscillator
`timescale 1ns/1ps
module sp_core_model (
  input wire sp_pkg::sp_cpu_req_t cpu_req,
  output logic [15:0] flash_rdata,
  output logic rc_osc
);
  import sp_pkg::*;
  // flash word follows the z pointer in the same cycle, distinct halves
  assign flash_rdata = {cpu_req.z[8:1] ^ 8'hA5, cpu_req.z[8:1]};
  // rc oscillator runs free, phase unrelated to ref_clk
  initial begin
    rc_osc = 1'b0;
    forever #17 rc_osc = ~rc_osc;
  end
endmodule : sp_core_model

// ### bench/test_sp_selfprog.sv
// self-checking bench for the self-programming block
`timescale 1ns/1ps
`include "sp_regs.svh"
module test_sp_selfprog;
  import sp_pkg::*;
  logic ref_clk = 1'b0, rst_b = 1'b0, por_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, eeprom_busy = 1'b0;
  logic [5:0] reg_addr = 6'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata, lpm_data, rd;
  logic lpm_valid, rww_busy, rc_osc;
  logic [15:0] flash_rdata;
  sp_cpu_req_t cpu_req = '0;
  sp_flash_op_t flash_op;
  int failures = 0, num_checks = 0, cnt;
  // rows: signature z address beside the expected byte
  logic [15:0] rows [9] = '{16'h0040, 16'h0141, 16'h0242, 16'h0444, 16'h0E4E, 16'h1353, 16'h14FF, 16'h1757,
    16'h03FF};
  // signature row content: byte i holds 0x40 + i (arbitrary)
  function automatic logic [8*`SP_ROW_BYTES-1:0] mk_row();
    for (int i = 0; i < `SP_ROW_BYTES; i++) mk_row[8*i+:8] = 8'h40 + i[7:0];
  endfunction : mk_row
  always #2 ref_clk = ~ref_clk;
  // rc scaled to 5 khz: one flash write is 16 ticks of the 34 ns model oscillator
  sp_selfprog #(.RC_KHZ(5), .SIG_ROW(mk_row())) uut (.ref_clk(ref_clk), .rst_b(rst_b), .por_b(por_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cpu_req(cpu_req), .flash_rdata(flash_rdata), .eeprom_busy(eeprom_busy), .rc_osc(rc_osc),
    .lpm_data(lpm_data), .lpm_valid(lpm_valid), .flash_op(flash_op), .rww_busy(rww_busy));
  sp_core_model partner (.cpu_req(cpu_req), .flash_rdata(flash_rdata), .rc_osc(rc_osc));
  // compare and count
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic print_verdict();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  // one-cycle register write
  task automatic wr(input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= `SP_CTRL_ADDR;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // one-cycle register read, data taken in the following cycle
  task automatic rdr(input logic [5:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask : rdr
  // load or store pulse after n idle cycles
  task automatic op(input logic l, input logic s, input logic [15:0] z, input int n);
    repeat (n) @(posedge ref_clk);
    cpu_req <= '{l, s, z};
    @(posedge ref_clk);
    cpu_req.lpm <= 1'b0;
    cpu_req.spm <= 1'b0;
    #1;
  endtask : op
  // bounded wait for the running flash write to end
  task automatic wait_idle();
    cnt = 0;
    while (flash_op !== '0) begin
      @(posedge ref_clk);
      #1 cnt++;
      if (cnt > 300) begin
        failures++;
        print_verdict();
      end
    end
  endtask : wait_idle
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    por_b <= 1'b1;
    rdr(`SP_CTRL_ADDR);
    chk("ctrl_reset", rd, `SP_CTRL_RST);
    rdr(6'h21);
    chk("unmapped", rd, 8'h00);
    $display("test reset done");
    // signature reads at cycles 1..3 after arming
    foreach (rows[i]) begin
      wr(8'h21);
      op(1'b1, 1'b0, {8'h00, rows[i][15:8]}, i % 3);
      chk("sig_valid", lpm_valid, 1'b1);
      chk("sig_byte", lpm_data, rows[i][7:0]);
      rdr(`SP_CTRL_ADDR);
      chk("sig_clear", rd, 8'h00);
    end
    $display("test signature table done");
    // load one cycle late reads flash, arming gone
    wr(8'h21);
    op(1'b1, 1'b0, 16'h0003, 3);
    chk("late_lpm", lpm_data, 8'hA4);
    rdr(`SP_CTRL_ADDR);
    chk("late_clear", rd, 8'h00);
    // control write dropped while eeprom busy
    @(posedge ref_clk);
    eeprom_busy <= 1'b1;
    wr(8'h21);
    op(1'b1, 1'b0, 16'h0004, 0);
    chk("ee_busy_lpm", lpm_data, 8'h02);
    @(posedge ref_clk);
    eeprom_busy <= 1'b0;
    $display("test timeout done");
    // store at cycle 5 refused, at cycle 4 accepted
    wr(8'h03);
    op(1'b0, 1'b1, 16'h0040, 4);
    chk("spm_late", flash_op.erase, 1'b0);
    wr(8'h03); // eeprom idle, no command running
    op(1'b0, 1'b1, 16'h0040, 3);
    chk("spm_erase", flash_op.erase, 1'b1);
    chk("busy_set", rww_busy, 1'b1);
    chk("erase_word", {flash_op.halt, flash_op.word}, {1'b0, 15'h0020});
    // core model takes no interrupts while a write runs, only these loads
    op(1'b1, 1'b0, 16'h0100, 1);
    chk("blocked_read", lpm_data, 8'hFF);
    rdr(`SP_CTRL_ADDR);
    chk("ctrl_running", rd & 8'h41, 8'h41);
    wait_idle();
    chk("erase_len", (cnt >= 120 && cnt <= 150), 1'b1);
    rdr(`SP_CTRL_ADDR);
    chk("ctrl_done", rd, 8'h40);
    wr(8'h11); // re-enable after busy flag seen
    op(1'b0, 1'b1, 16'h0000, 0);
    chk("busy_clear", rww_busy, 1'b0);
    $display("test erase done");
    // system reset during page write does not abort it
    wr(8'h05);
    op(1'b0, 1'b1, 16'h0040, 0);
    @(posedge ref_clk);
    rst_b <= 1'b0;
    @(posedge ref_clk);
    rst_b <= 1'b1;
    #1 chk("write_kept", flash_op.write, 1'b1);
    wait_idle();
    chk("write_len", (cnt >= 120 && cnt <= 150), 1'b1);
    chk("busy_kept", rww_busy, 1'b1);
    $display("test reset during write done");
    // lock-bit set: no halt, busy flag untouched
    wr(8'h09);
    op(1'b0, 1'b1, 16'h0001, 0);
    chk("lock_set", {flash_op.lock, flash_op.halt, rww_busy}, 3'b101);
    wait_idle();
    chk("lock_len", (cnt >= 120 && cnt <= 150), 1'b1);
    // page write into the upper section halts the core
    wr(8'h05);
    op(1'b0, 1'b1, 16'h1800, 0);
    chk("halt_word", {flash_op.halt, flash_op.word}, {1'b1, 15'h0C00});
    wait_idle();
    chk("halt_done", flash_op.halt, 1'b0);
    $display("test lock and halt done");
    print_verdict();
  end
endmodule : test_sp_selfprog
